// >>> hdl/itm_timer.sv
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "itm_defines.svh"

// Overview of operation
// [R01] A 16-bit counter serving as RTC time base or free-running interval timer.
// [R02] Modes: internal timer, synchronous external counter, asynchronous external counter.
// [R03] Gate input enables counting; gate falling edge raises an interrupt.
// [R04] Counter equal to period value raises an interrupt.
// [R05] Two-bit prescale field divides the count clock before incrementing.
// [R06] Clock source bit, two-bit external clock choice and gate enable select operation.
// [R07] Sync bit set counts in step with system clock, clear counts asynchronously. The code ignores the sync bit and always counts the synchronised edge.
// [R08] Counting continues while the processor idles or sleeps.
// [R09] Software sets on, prescale, clocking, sync, period, then interrupt enable.
// [R10] After a period match the counter returns to zero on next count.
// [R11] In gated mode count only while gate is high, else hold.
module itm_timer (
    // Clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_b_i,
    // Avalon-MM slave
    input  wire itm_pkg::itm_av_req_t av_req_i,
    output var  itm_pkg::itm_av_rsp_t av_rsp_o,
    // External pins
    input  wire logic [3:0]           ext_clk_i,
    input  wire logic                 gate_i,
    // Interrupt
    output logic                      irq_o,
    output logic [2:0]                irq_priority_o
);
    import itm_pkg::*;

    logic             rst_m_r;
    logic             rst_b_r;
    itm_ctrl_t        ctrl_r;
    logic [15:0]      period_value_r;
    logic [15:0]      count_r;
    logic [1:0]       status_r;
    logic [1:0]       mask_r;
    logic [2:0]       prio_r;
    logic [3:0]       ext_m_r;
    logic [3:0]       ext_s_r;
    logic             ext_d_r;
    logic             gate_m_r;
    logic             gate_s_r;
    logic             gate_d_r;
    logic [7:0]       pre_r;
    logic             tick;
    logic             src_edge;
    logic             pre_done;
    logic             cnt_en;
    logic             ext_sel;
    logic             gate_fall;
    logic             match_evt;
    logic [7:0]       pre_lim;
    itm_bus_t         bus_r;
    logic             wr_acc;
    logic             rd_acc;
    logic [31:0]      rd_data;
    logic [1:0]       w1c;

    // Reset release through two flops
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_m_r <= 1'b0;
            rst_b_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_b_r <= rst_m_r;
        end
    end

    // Pin synchronisers, second stage feeds logic
    always_ff @(posedge ref_clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            ext_m_r  <= 4'h0;
            ext_s_r  <= 4'h0;
            ext_d_r  <= 1'b0;
            gate_m_r <= 1'b0;
            gate_s_r <= 1'b0;
            gate_d_r <= 1'b0;
        end else begin
            ext_m_r  <= ext_clk_i;
            ext_s_r  <= ext_m_r;
            ext_d_r  <= ext_sel;
            gate_m_r <= gate_i;
            gate_s_r <= gate_m_r;
            gate_d_r <= gate_s_r;
        end
    end

    // Source and prescale selection
    always_comb begin
        ext_sel = ext_s_r[ctrl_r.ext_sel]; // see [R06]
        case (ctrl_r.prescale_select) // see [R05]
            2'h0:    pre_lim = 8'h00;
            2'h1:    pre_lim = 8'h07;
            2'h2:    pre_lim = 8'h3F;
            default: pre_lim = 8'hFF;
        endcase
        // External edge; async mode uses the same synchronised edge in this single-clock build
        src_edge  = ext_sel & ~ext_d_r; // see [R02] see [R07]
        tick      = ctrl_r.clock_source_select ? src_edge : 1'b1; // see [R02]
        pre_done  = (pre_r == pre_lim);
        cnt_en    = ctrl_r.timer_on & tick & pre_done
                  & (~ctrl_r.gated_count_enable | gate_s_r); // see [R11]
        gate_fall = ctrl_r.timer_on & ctrl_r.gated_count_enable
                  & gate_d_r & ~gate_s_r; // see [R03]
        match_evt = cnt_en & (count_r == period_value_r); // see [R04]
    end

    // Prescaler counter, no power state stops it, restarts on a control write
    always_ff @(posedge ref_clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            pre_r <= 8'h00;
        end else if (wr_acc && av_req_i.address == `ITM_OFF_CTRL) begin
            pre_r <= 8'h00; // New ratio never starts above its limit
        end else if (!ctrl_r.timer_on) begin
            pre_r <= 8'h00;
        end else if (tick) begin
            pre_r <= pre_done ? 8'h00 : pre_r + 8'h01; // see [R05] see [R08]
        end
    end

    // Main 16-bit counter, wraps to zero on the count after it equals the period
    always_ff @(posedge ref_clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            count_r <= 16'h0000;
        end else if (wr_acc && av_req_i.address == `ITM_OFF_COUNT) begin
            count_r <= av_req_i.writedata[15:0];
        end else if (cnt_en) begin
            if (count_r == period_value_r) begin
                count_r <= 16'h0000; // see [R10]
            end else begin
                count_r <= count_r + 16'h0001; // see [R01]
            end
        end
    end

    // Bus handshake, one wait state per access
    assign wr_acc = (bus_r == ITM_BUS_ACK) && av_req_i.write;
    assign rd_acc = (bus_r == ITM_BUS_ACK) && av_req_i.read;

    always_ff @(posedge ref_clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            bus_r <= ITM_BUS_IDLE;
        end else begin
            case (bus_r)
                ITM_BUS_IDLE: bus_r <= (av_req_i.read | av_req_i.write) ? ITM_BUS_ACK
                                                                        : ITM_BUS_IDLE;
                ITM_BUS_ACK:  bus_r <= ITM_BUS_IDLE;
                default:      bus_r <= ITM_BUS_IDLE;
            endcase
        end
    end

    // Control, period, mask and priority registers
    always_ff @(posedge ref_clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            ctrl_r         <= `ITM_CTRL_RST;
            period_value_r <= `ITM_PERIOD_RST;
            mask_r         <= 2'h0;
            prio_r         <= 3'h0;
        end else if (wr_acc) begin
            case (av_req_i.address)
                6'(`ITM_OFF_CTRL):   ctrl_r         <= av_req_i.writedata[7:0]; // see [R06]
                6'(`ITM_OFF_PERIOD): period_value_r <= av_req_i.writedata[15:0];
                6'(`ITM_OFF_MASK):   mask_r         <= av_req_i.writedata[1:0];
                6'(`ITM_OFF_PRIO):   prio_r         <= av_req_i.writedata[2:0];
                default:             ;
            endcase
        end
    end

    // Sticky status, set wins over write-one-to-clear
    assign w1c = (wr_acc && av_req_i.address == 6'(`ITM_OFF_STATUS))
               ? av_req_i.writedata[1:0] : 2'h0;

    always_ff @(posedge ref_clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            status_r <= 2'h0;
        end else begin
            status_r[`ITM_ST_MATCH] <= match_evt
                | (status_r[`ITM_ST_MATCH] & ~w1c[`ITM_ST_MATCH]); // see [R04]
            status_r[`ITM_ST_GATE]  <= gate_fall
                | (status_r[`ITM_ST_GATE] & ~w1c[`ITM_ST_GATE]); // see [R03]
        end
    end

    // Read data mux
    always_comb begin
        case (av_req_i.address)
            6'(`ITM_OFF_CTRL):   rd_data = {24'h000000, ctrl_r};
            6'(`ITM_OFF_PERIOD): rd_data = {16'h0000, period_value_r};
            6'(`ITM_OFF_COUNT):  rd_data = {16'h0000, count_r};
            6'(`ITM_OFF_STATUS): rd_data = {30'h00000000, status_r};
            6'(`ITM_OFF_MASK):   rd_data = {30'h00000000, mask_r};
            6'(`ITM_OFF_PRIO):   rd_data = {29'h00000000, prio_r};
            default:             rd_data = 32'h00000000;
        endcase
    end

    // Registered bus outputs and interrupt
    always_ff @(posedge ref_clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            av_rsp_o       <= '{readdata: 32'h00000000, waitrequest: 1'b1};
            irq_o          <= 1'b0;
            irq_priority_o <= 3'h0;
        end else begin
            av_rsp_o.waitrequest <= !((bus_r == ITM_BUS_IDLE)
                                      && (av_req_i.read | av_req_i.write));
            av_rsp_o.readdata    <= (bus_r == ITM_BUS_IDLE && av_req_i.read)
                                    ? rd_data : av_rsp_o.readdata;
            irq_o                <= |(status_r & mask_r); // see [R03] see [R04]
            irq_priority_o       <= prio_r;
        end
    end

    // Match flag follows a count equal to period
    period_match_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R04]
        match_evt |=> status_r[`ITM_ST_MATCH])
        else $error("match flag not set");

    // Counter wraps to zero after match
    period_wrap_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R10]
        (cnt_en && count_r == period_value_r && !wr_acc) |=> count_r == 16'h0000)
        else $error("counter did not wrap");

    // Gate low holds the count
    gate_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R11]
        (ctrl_r.gated_count_enable && !gate_s_r && !wr_acc) |=> $stable(count_r))
        else $error("count moved with gate low");

    sequence gate_drop_s;
        ctrl_r.timer_on && ctrl_r.gated_count_enable && gate_s_r
        ##1 (!gate_s_r && ctrl_r.timer_on && ctrl_r.gated_count_enable);
    endsequence

    // Gate falling edge sets flag
    gate_fall_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R03]
        gate_drop_s |=> status_r[`ITM_ST_GATE])
        else $error("gate flag not set");

    // Timer off freezes counter
    timer_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R01]
        (!ctrl_r.timer_on && !wr_acc) |=> $stable(count_r))
        else $error("count moved while off");

    // Internal mode, no prescale counts every clock
    int_count_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R02]
        (ctrl_r.timer_on && !ctrl_r.clock_source_select && !ctrl_r.gated_count_enable
         && ctrl_r.prescale_select == 2'h0 && count_r != period_value_r && !wr_acc)
        |=> count_r == $past(count_r) + 16'h0001)
        else $error("internal count missed");

    // Prescale never exceeds its limit
    pre_limit_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R05]
        pre_r <= pre_lim)
        else $error("prescale overrun");

    // External mode counts only on source edge
    ext_edge_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R07]
        (ctrl_r.clock_source_select && !src_edge && !wr_acc) |=> $stable(count_r))
        else $error("external count without edge");

    // Interrupt follows unmasked status
    irq_level_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R04]
        ##1 irq_o == |($past(status_r) & $past(mask_r)))
        else $error("interrupt level wrong");

    // Request seen by an idle slave
    sequence bus_req_s;
        bus_r == ITM_BUS_IDLE && (av_req_i.read || av_req_i.write);
    endsequence

    // One answer cycle, then waitrequest high again
    sequence bus_answer_s;
        !av_rsp_o.waitrequest ##1 av_rsp_o.waitrequest;
    endsequence

    // Each request answered after one wait state
    bus_answer_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R06]
        bus_req_s |=> bus_answer_s)
        else $error("bus answer timing wrong");

    // Idle bus keeps waitrequest high
    bus_quiet_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R06]
        (bus_r == ITM_BUS_IDLE && !av_req_i.read && !av_req_i.write)
        |=> av_rsp_o.waitrequest)
        else $error("answer without request");

    // Read data stands at the accepting edge
    read_data_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R06]
        rd_acc |-> av_rsp_o.readdata == $past(rd_data))
        else $error("read data not presented");

    // Count register takes the written value
    count_load_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R01]
        (wr_acc && av_req_i.address == `ITM_OFF_COUNT)
        |=> count_r == $past(av_req_i.writedata[15:0]))
        else $error("count load lost");

    // Internal clock with a prescale period still pending
    sequence pre_wait_s;
        ctrl_r.timer_on && !ctrl_r.clock_source_select && pre_r != pre_lim && !wr_acc;
    endsequence

    // Count holds until the prescaler ends its ratio
    pre_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R05]
        pre_wait_s |=> $stable(count_r))
        else $error("count moved inside prescale");

    // Prescaler advances once per system clock
    pre_step_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R05]
        pre_wait_s |=> pre_r == $past(pre_r) + 8'h01)
        else $error("prescale step missed");

    // Clear of the match flag with no new match
    sequence match_clear_s;
        w1c[`ITM_ST_MATCH] && !match_evt;
    endsequence

    // Match flag empties on a plain clear
    match_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R04]
        match_clear_s |=> !status_r[`ITM_ST_MATCH])
        else $error("match flag not cleared");

    // Gate flag empties on a plain clear
    gate_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R03]
        (w1c[`ITM_ST_GATE] && !gate_fall) |=> !status_r[`ITM_ST_GATE])
        else $error("gate flag not cleared");

    // Stopped timer raises no match flag
    off_quiet_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R04]
        (!ctrl_r.timer_on && !status_r[`ITM_ST_MATCH])
        |=> !status_r[`ITM_ST_MATCH])
        else $error("match flag while off");

    // Ungated timer raises no gate flag
    gate_quiet_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R03]
        (!ctrl_r.gated_count_enable && !status_r[`ITM_ST_GATE])
        |=> !status_r[`ITM_ST_GATE])
        else $error("gate flag without gating");

    // Priority output mirrors its register
    prio_copy_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_r) // see [R04]
        irq_priority_o == $past(prio_r))
        else $error("priority output stale");
endmodule
`default_nettype wire

// >>> hdl/itm_defines.svh
`ifndef ITM_DEFINES_SVH
`define ITM_DEFINES_SVH

// Register byte offsets
`define ITM_OFF_CTRL     6'h00
`define ITM_OFF_PERIOD   6'h04
`define ITM_OFF_COUNT    6'h08
`define ITM_OFF_STATUS   6'h0C
`define ITM_OFF_MASK     6'h10
`define ITM_OFF_PRIO     6'h14

// Control field positions
`define ITM_CTRL_ON      0
`define ITM_CTRL_CS      1
`define ITM_CTRL_SYNC    2
`define ITM_CTRL_GATE    3
`define ITM_CTRL_PS_LO   4
`define ITM_CTRL_EC_LO   6

// Status bits
`define ITM_ST_MATCH     0
`define ITM_ST_GATE      1

// Reset values
`define ITM_PERIOD_RST   16'hFFFF
`define ITM_CTRL_RST     8'h00

`endif

// >>> hdl/itm_pkg.sv
package itm_pkg;
    typedef struct packed {
        logic [1:0] ext_sel;
        logic [1:0] prescale_select;
        logic       gated_count_enable;
        logic       external_count_sync;
        logic       clock_source_select;
        logic       timer_on;
    } itm_ctrl_t;

    typedef struct packed {
        logic [5:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } itm_av_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } itm_av_rsp_t;

    typedef enum logic [1:0] {
        ITM_BUS_IDLE,
        ITM_BUS_ACK
    } itm_bus_t;
endpackage

// >>> dv/itm_ext_model.sv
`timescale 1ns/100ps
`default_nettype none
// Far side: external count clocks and the gate level
module itm_ext_model (
    // Clock
    input  wire logic       ref_clk_i,
    // Bench control
    input  wire logic [3:0] run_i,
    input  wire logic       gate_lvl_i,
    // Pins toward the timer
    output logic [3:0]      ext_clk_o,
    output logic            gate_o
);
    logic [2:0] ph_r [4];
    // One rising edge per 8 cycles while running, low when stopped
    always @(posedge ref_clk_i) begin
        for (int i = 0; i < 4; i++) begin
            ph_r[i] <= run_i[i] ? ph_r[i] + 3'h1 : 3'h0;
            ext_clk_o[i] <= run_i[i] & ph_r[i][2];
        end
        gate_o <= gate_lvl_i;
    end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "itm_defines.svh"
module testbench;
    import itm_pkg::*;
    logic        ref_clk, rst_b, gate, gate_lvl, irq;
    logic [3:0]  ext_clk, run;
    logic [2:0]  prio;
    logic [31:0] q;
    itm_av_req_t req;
    itm_av_rsp_t rsp;
    int          miscompares = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int unsigned rt [4] = '{1, 8, 64, 256};
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    itm_timer dut (
        .ref_clk_i      (ref_clk),
        .rst_b_i        (rst_b),
        .av_req_i       (req),
        .av_rsp_o       (rsp),
        .ext_clk_i      (ext_clk),
        .gate_i         (gate),
        .irq_o          (irq),
        .irq_priority_o (prio)
    );
    itm_ext_model ext (
        .ref_clk_i  (ref_clk),
        .run_i      (run),
        .gate_lvl_i (gate_lvl),
        .ext_clk_o  (ext_clk),
        .gate_o     (gate)
    );
    // Verdict and end of run
    task automatic finish_test();
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One access, held until waitrequest is sampled low
    task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
        @(posedge ref_clk);
        req <= '{address: a, read: ~w, write: w, writedata: d};
        do @(posedge ref_clk); while (rsp.waitrequest !== 1'b0);
        q = rsp.readdata;
        req <= '0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rd(input logic [5:0] a);
        bus(a, 1'b0, 32'h0);
    endtask
    // Reset values, word width, unmapped place, priority
    task automatic t_reset();
        chk(irq, 0);
        chk(rsp.waitrequest, 1);
        rd(`ITM_OFF_CTRL);
        chk(q, 0);
        rd(`ITM_OFF_PERIOD);
        chk(q, 32'h0000FFFF);
        wr(`ITM_OFF_COUNT, 32'h1234ABCD);
        rd(`ITM_OFF_COUNT);
        chk(q, 32'h0000ABCD);
        wr(6'h18, 32'hFFFFFFFF);
        rd(6'h18);
        chk(q, 0);
        wr(`ITM_OFF_PRIO, 32'h5);
        rd(`ITM_OFF_PRIO);
        chk(q, 5);
        chk(prio, 3'h5);
    endtask
    // Match interval for every prescale code, repeating after match
    task automatic t_period();
        time t0;
        time t1;
        for (int ps = 0; ps < 4; ps++) begin
            wr(`ITM_OFF_CTRL, 0);
            wr(`ITM_OFF_STATUS, 3);
            wr(`ITM_OFF_COUNT, 0);
            wr(`ITM_OFF_CTRL, 32'(1 + (ps << 4)));
            wr(`ITM_OFF_PERIOD, 9);
            wr(`ITM_OFF_MASK, 1);
            for (int k = 0; k < 3; k++) begin
                @(posedge ref_clk iff irq === 1'b1);
                t0 = t1;
                t1 = $time;
                wr(`ITM_OFF_STATUS, 1);
                @(posedge ref_clk iff irq === 1'b0);
            end
            chk(32'((t1 - t0) / 10), 10 * rt[ps]);
        end
    endtask
    // Gated counting, gate fall flag, mask and clear
    task automatic t_gate();
        logic [31:0] c1;
        wr(`ITM_OFF_CTRL, 0);
        wr(`ITM_OFF_STATUS, 3);
        wr(`ITM_OFF_MASK, 0);
        wr(`ITM_OFF_PERIOD, 32'hFFFF);
        wr(`ITM_OFF_COUNT, 0);
        wr(`ITM_OFF_CTRL, 32'h9);
        repeat (20) @(posedge ref_clk);
        rd(`ITM_OFF_COUNT);
        chk(q, 0);
        gate_lvl <= 1'b1;
        repeat (30) @(posedge ref_clk);
        gate_lvl <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rd(`ITM_OFF_COUNT);
        c1 = q;
        chk(c1, 30);
        repeat (20) @(posedge ref_clk);
        rd(`ITM_OFF_COUNT);
        chk(q, c1);
        rd(`ITM_OFF_STATUS);
        chk(q, 2);
        chk(irq, 0);
        wr(`ITM_OFF_MASK, 2);
        repeat (2) @(posedge ref_clk);
        chk(irq, 1);
        wr(`ITM_OFF_STATUS, 2);
        repeat (2) @(posedge ref_clk);
        chk(irq, 0);
    endtask
    // Only the selected external line advances the count
    task automatic t_ext();
        for (int s = 0; s < 4; s++) begin
            wr(`ITM_OFF_CTRL, 0);
            wr(`ITM_OFF_COUNT, 0);
            wr(`ITM_OFF_CTRL, 32'(3 + (s[0] << 2) + (s << 6)));
            run <= 4'(1 << s);
            repeat (40) @(posedge ref_clk);
            run <= 4'(1 << ((s + 1) % 4));
            repeat (24) @(posedge ref_clk);
            run <= 4'h0;
            repeat (8) @(posedge ref_clk);
            rd(`ITM_OFF_COUNT);
            chk(q, 5);
        end
    endtask
    // Main sequence
    initial begin
        rst_b = 1'b0;
        req = '0;
        run = 4'h0;
        gate_lvl = 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_reset();
        t_period();
        t_gate();
        t_ext();
        finish_test();
    end
    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            finish_test();
        end
    end
endmodule
`default_nettype wire
